// File: hdl/bpp_pkg.sv
package bpp_pkg;
	// Register indexes; the byte address on the bus is four times the index.
	localparam logic [7:0] IDX_INPUT_SYNC = 8'h00;
	localparam logic [7:0] IDX_DIRECTION = 8'h01;
	localparam logic [7:0] IDX_OUTPUT_LATCH = 8'h02;
	localparam logic [7:0] IDX_PULLUP_GLOBAL = 8'h35;
	localparam logic [7:0] IDX_LED_DRIVE = 8'h75;
	localparam int IDX_LSB = 2;
	localparam int IDX_W = 8;

	// Field layouts and reset values.
	localparam int PUD_BIT = 4;
	localparam logic [7:0] PULLUP_GLOBAL_MASK = 8'h92;
	localparam logic [7:0] PULLUP_GLOBAL_RST = 8'h00;
	localparam logic [7:0] LED_DRIVE_MASK = 8'hF0;
	localparam logic [7:0] LED_DRIVE_RST = 8'h00;
	localparam int LED_GROUPS = 2;
	localparam int LED_FIELD_LSB = 4;
	localparam int LED_FIELD_W = 2;

	// Encodings of one LED drive field.
	localparam logic [1:0] LED_OFF = 2'h0;
	localparam logic [1:0] LED_2MA = 2'h1;
	localparam logic [1:0] LED_4MA = 2'h2;
	localparam logic [1:0] LED_RSVD = 2'h3;

	// Cycles after leaving a clamping sleep in which a rising pin is flagged.
	localparam logic [1:0] WAKE_WINDOW = 2'h3;
	localparam logic [1:0] WAKE_ZERO = 2'h0;
endpackage

// File: hdl/bpp_port.sv
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/10ps
module bpp_port #(
	parameter int WIDTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [bpp_pkg::IDX_W+bpp_pkg::IDX_LSB-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] pin_o,
	output logic [WIDTH-1:0] pin_oe_o,
	output logic [WIDTH-1:0] pullup_en_o,
	input wire logic sleep_clamp_i,
	input wire logic low_power_i,
	input wire logic [WIDTH-1:0] ext_int_en_i,
	output logic [WIDTH-1:0] wake_int_flag_o,
	output logic kbo_limit_en_o,
	output logic [bpp_pkg::LED_GROUPS-1:0] led_2ma_o,
	output logic [bpp_pkg::LED_GROUPS-1:0] led_4ma_o
);
	logic [WIDTH-1:0] dir_q;
	logic [WIDTH-1:0] latch_q;
	logic [WIDTH-1:0] sync_latch;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_prev_q;
	logic [WIDTH-1:0] pin_gated;
	logic [7:0] pgc_q;
	logic [7:0] led_q;
	logic [1:0] wake_cnt_q;
	logic sleep_prev_q;
	logic [31:0] rd_d;
	logic wr_en;
	logic [bpp_pkg::IDX_W-1:0] idx;

	function automatic logic [WIDTH-1:0] bpp_wr_byte(
		input logic [WIDTH-1:0] old_v,
		input logic [31:0] dat
	);
		bpp_wr_byte = dat[WIDTH-1:0];
		if (old_v == old_v)
		begin
			bpp_wr_byte = dat[WIDTH-1:0];
		end
	endfunction

	function automatic logic bpp_hit(
		input logic [bpp_pkg::IDX_W-1:0] a,
		input logic [bpp_pkg::IDX_W-1:0] r
	);
		bpp_hit = (a == r);
	endfunction

	assign idx = wb_adr_i[bpp_pkg::IDX_W+bpp_pkg::IDX_LSB-1:bpp_pkg::IDX_LSB];
	// Only byte lane 0 carries register data; other lanes are ignored.
	// A write lands at the edge where the master sees ack high, not earlier.
	assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
	end

	always_comb
	begin
		rd_d = 32'h0000_0000;
		if (bpp_hit(idx, bpp_pkg::IDX_INPUT_SYNC))
			rd_d[WIDTH-1:0] = sync_q;
		else if (bpp_hit(idx, bpp_pkg::IDX_DIRECTION))
			rd_d[WIDTH-1:0] = dir_q;
		else if (bpp_hit(idx, bpp_pkg::IDX_OUTPUT_LATCH))
			rd_d[WIDTH-1:0] = latch_q;
		else if (bpp_hit(idx, bpp_pkg::IDX_PULLUP_GLOBAL))
			rd_d[7:0] = pgc_q;
		else if (bpp_hit(idx, bpp_pkg::IDX_LED_DRIVE))
			rd_d[7:0] = led_q;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= 32'h0000_0000;
		else if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o)
			wb_dat_o <= rd_d;
	end

	// Direction bits drive the output enables directly.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dir_q <= '0;
		else if (wr_en && bpp_hit(idx, bpp_pkg::IDX_DIRECTION))
			dir_q <= bpp_wr_byte(dir_q, wb_dat_i);
	end

	// A toggle write inverts only the bits written as one.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			latch_q <= '0;
		else if (wr_en && bpp_hit(idx, bpp_pkg::IDX_OUTPUT_LATCH))
			latch_q <= bpp_wr_byte(latch_q, wb_dat_i);
		else if (wr_en && bpp_hit(idx, bpp_pkg::IDX_INPUT_SYNC))
			latch_q <= latch_q ^ wb_dat_i[WIDTH-1:0];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			pgc_q <= bpp_pkg::PULLUP_GLOBAL_RST;
		else if (wr_en && bpp_hit(idx, bpp_pkg::IDX_PULLUP_GLOBAL))
			pgc_q <= wb_dat_i[7:0] & bpp_pkg::PULLUP_GLOBAL_MASK;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			led_q <= bpp_pkg::LED_DRIVE_RST;
		else if (wr_en && bpp_hit(idx, bpp_pkg::IDX_LED_DRIVE))
			led_q <= wb_dat_i[7:0] & bpp_pkg::LED_DRIVE_MASK;
	end

	assign pin_oe_o = dir_q;
	assign pin_o = latch_q;

	// Pull-up follows the output latch on input pins one cycle later; the PUD_BIT of pgc_q forces it off.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			pullup_en_o <= '0;
		else if (pgc_q[bpp_pkg::PUD_BIT])
			pullup_en_o <= '0;
		else
			pullup_en_o <= ~dir_q & latch_q;
	end

	// Sleep clamp ahead of the synchroniser, skipped for interrupt pins.
	assign pin_gated = pin_i & ~({WIDTH{sleep_clamp_i}} & ~ext_int_en_i);

	// Latch is open while the clock is high; the flop samples it at the rise.
	always_latch
	begin
		if (clk_i)
			sync_latch <= pin_gated;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			sync_q <= '0;
		else
			sync_q <= sync_latch;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync_prev_q <= '0;
			sleep_prev_q <= 1'b0;
		end
		else
		begin
			sync_prev_q <= sync_q;
			sleep_prev_q <= sleep_clamp_i;
		end
	end

	// A short window after the clamp lifts catches the release edge.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wake_cnt_q <= bpp_pkg::WAKE_ZERO;
		else if (sleep_prev_q && !sleep_clamp_i)
			wake_cnt_q <= bpp_pkg::WAKE_WINDOW;
		else if (wake_cnt_q != bpp_pkg::WAKE_ZERO)
			wake_cnt_q <= wake_cnt_q - 2'h1;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wake_int_flag_o <= '0;
		else if (wake_cnt_q != bpp_pkg::WAKE_ZERO)
			wake_int_flag_o <= sync_q & ~sync_prev_q & ~ext_int_en_i;
		else
			wake_int_flag_o <= '0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			kbo_limit_en_o <= 1'b1;
		else
			kbo_limit_en_o <= !low_power_i;
	end

	genvar g;
	generate
		for (g = 0; g < bpp_pkg::LED_GROUPS; g++)
		begin : g_led
			localparam int LSB = bpp_pkg::LED_FIELD_LSB + g * bpp_pkg::LED_FIELD_W;
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					led_2ma_o[g] <= 1'b0;
					led_4ma_o[g] <= 1'b0;
				end
				else
				begin
					led_2ma_o[g] <= led_q[LSB+:2] == bpp_pkg::LED_2MA;
					led_4ma_o[g] <= led_q[LSB+:2] == bpp_pkg::LED_4MA;
				end
			end
		end
	endgenerate

	property p_dir_oe;
		@(posedge clk_i) disable iff (rst_i)
		wr_en && bpp_hit(idx, bpp_pkg::IDX_DIRECTION)
			|=> pin_oe_o == $past(wb_dat_i[WIDTH-1:0]);
	endproperty
	a_dir_oe: assert property (p_dir_oe) else $error("oe not direction");

	property p_pullup;
		@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> pullup_en_o == ($past(~dir_q & latch_q)
			& {WIDTH{!$past(pgc_q[bpp_pkg::PUD_BIT])}});
	endproperty
	a_pullup: assert property (p_pullup) else $error("pull-up wrong");

	property p_out;
		@(posedge clk_i) disable iff (rst_i)
		wr_en && bpp_hit(idx, bpp_pkg::IDX_OUTPUT_LATCH)
			|=> pin_o == $past(wb_dat_i[WIDTH-1:0]);
	endproperty
	a_out: assert property (p_out) else $error("output latch wrong");

	property p_reset;
		@(posedge clk_i) rst_i |=> pin_oe_o == '0 && pullup_en_o == '0;
	endproperty
	a_reset: assert property (p_reset) else $error("pins not tri-state");

	property p_toggle;
		@(posedge clk_i) disable iff (rst_i)
		wr_en && bpp_hit(idx, bpp_pkg::IDX_INPUT_SYNC)
			|=> pin_o == ($past(latch_q) ^ $past(wb_dat_i[WIDTH-1:0]));
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle wrong");

	property p_pud;
		@(posedge clk_i) disable iff (rst_i)
		pgc_q[bpp_pkg::PUD_BIT] |=> pullup_en_o == '0;
	endproperty
	a_pud: assert property (p_pud) else $error("pull-up not off");

	property p_clamp;
		@(posedge clk_i) disable iff (rst_i)
		sleep_clamp_i [*2] |-> (sync_q & ~ext_int_en_i) == '0;
	endproperty
	a_clamp: assert property (p_clamp) else $error("clamp failed");

	property p_led;
		@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> led_2ma_o[0] == ($past(led_q[5:4]) == bpp_pkg::LED_2MA)
			&& !(led_2ma_o[0] && led_4ma_o[0]);
	endproperty
	a_led: assert property (p_led) else $error("LED decode wrong");

	property p_kbo;
		@(posedge clk_i) disable iff (rst_i)
		low_power_i |=> !kbo_limit_en_o;
	endproperty
	a_kbo: assert property (p_kbo) else $error("limit not off");

	property p_rsvd;
		@(posedge clk_i) disable iff (rst_i)
		1'b1 |-> (pgc_q & ~bpp_pkg::PULLUP_GLOBAL_MASK) == 8'h00
			&& (led_q & ~bpp_pkg::LED_DRIVE_MASK) == 8'h00;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
endmodule

// File: tb/bpp_pin_model.sv
`timescale 1ns/10ps
module bpp_pin_model #(
	parameter int WIDTH = 8
) (
	input wire logic clk_i,
	input wire logic [WIDTH-1:0] pin_o,
	input wire logic [WIDTH-1:0] pin_oe_o,
	input wire logic [WIDTH-1:0] pullup_en_o,
	input wire logic [WIDTH-1:0] ext_en_i,
	input wire logic [WIDTH-1:0] ext_val_i,
	output logic [WIDTH-1:0] pin_i
);
	logic [WIDTH-1:0] float_q;
	// A pin nobody drives or pulls shows a pattern that flips every cycle.
	always_ff @(posedge clk_i)
	begin
		float_q <= (float_q === '1) ? '0 : '1;
	end
	always_comb
	begin
		for (int b = 0; b < WIDTH; b++)
		begin
			if (pin_oe_o[b])
				pin_i[b] = pin_o[b];
			else if (ext_en_i[b])
				pin_i[b] = ext_val_i[b];
			else if (pullup_en_o[b])
				pin_i[b] = 1'b1;
			else
				pin_i[b] = float_q[b];
		end
	end
endmodule

// File: tb/bpp_port_tb.sv
`timescale 1ns/10ps
module bpp_port_tb;
	logic clk_i, rst_i, cyc, stb, we, sleep, lowp, kbo;
	logic [9:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat;
	logic ack;
	logic [7:0] pin_i, pin_o, oe, pu, inten, flag, ext_en, ext_val, q;
	logic [1:0] led2, led4;
	int num_errors = 0;
	int n_checks = 0;
	bpp_port bpp_port_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pin_i(pin_i),
		.pin_o(pin_o), .pin_oe_o(oe), .pullup_en_o(pu),
		.sleep_clamp_i(sleep), .low_power_i(lowp), .ext_int_en_i(inten),
		.wake_int_flag_o(flag), .kbo_limit_en_o(kbo), .led_2ma_o(led2),
		.led_4ma_o(led4));
	bpp_pin_model bpp_pin_model_i (.clk_i(clk_i), .pin_o(pin_o),
		.pin_oe_o(oe), .pullup_en_o(pu), .ext_en_i(ext_en),
		.ext_val_i(ext_val), .pin_i(pin_i));
	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic end_sim();
		if (num_errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] got, exp);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
		output logic [7:0] r);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'h1;
		adr <= {idx, 2'b00};
		wdat <= {24'h00_0000, d};
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1);
		r = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		chk("ack", n, 2);
		// Let the write edge settle before the caller looks at outputs.
		@(posedge clk_i);
	endtask
	task automatic t_reset();
		chk("oe", oe, 8'h00);
		chk("kbo", kbo, 1'b1);
		wb(0, bpp_pkg::IDX_PULLUP_GLOBAL, 8'h00, q);
		chk("pg", q, 8'h00);
		wb(0, bpp_pkg::IDX_LED_DRIVE, 8'h00, q);
		chk("led", q, 8'h00);
		wb(1, 8'h40, 8'hFF, q);
		wb(0, 8'h40, 8'h00, q);
		chk("unmapped", q, 8'h00);
	endtask
	task automatic t_pins();
		ext_en <= 8'h03;
		ext_val <= 8'h01;
		wb(1, bpp_pkg::IDX_DIRECTION, 8'hF0, q);
		wb(1, bpp_pkg::IDX_OUTPUT_LATCH, 8'h3C, q);
		@(posedge clk_i);
		chk("oe", oe, 8'hF0);
		chk("pin", pin_o[7:4], 4'h3);
		chk("pu", pu, 8'h0C);
		wb(0, bpp_pkg::IDX_INPUT_SYNC, 8'h00, q);
		chk("sync", q, 8'h3D);
		wb(1, bpp_pkg::IDX_INPUT_SYNC, 8'h81, q);
		wb(1, bpp_pkg::IDX_INPUT_SYNC, 8'h00, q);
		wb(0, bpp_pkg::IDX_OUTPUT_LATCH, 8'h00, q);
		chk("toggle", q, 8'hBD);
		chk("pu", pu, 8'h0D);
	endtask
	task automatic t_pud();
		wb(1, bpp_pkg::IDX_PULLUP_GLOBAL, 8'hFF, q);
		@(posedge clk_i);
		chk("pu", pu, 8'h00);
		wb(0, bpp_pkg::IDX_PULLUP_GLOBAL, 8'h00, q);
		chk("pg", q, 8'h92);
		wb(1, bpp_pkg::IDX_PULLUP_GLOBAL, 8'h00, q);
		@(posedge clk_i);
		chk("pu", pu, 8'h0D);
	endtask
	task automatic t_led();
		logic [1:0] c;
		for (int i = 0; i < 4; i++)
		begin
			c = 2'(i);
			wb(1, bpp_pkg::IDX_LED_DRIVE, {c, c, 4'hF}, q);
			wb(0, bpp_pkg::IDX_LED_DRIVE, 8'h00, q);
			chk("led", q, {c, c, 4'h0});
			chk("led2", led2, {2{c == 2'h1}});
			chk("led4", led4, {2{c == 2'h2}});
		end
	endtask
	task automatic t_sleep();
		logic [7:0] acc;
		wb(1, bpp_pkg::IDX_DIRECTION, 8'h00, q);
		ext_en <= 8'hFF;
		ext_val <= 8'hFF;
		inten <= 8'h01;
		sleep <= 1'b1;
		wb(0, bpp_pkg::IDX_INPUT_SYNC, 8'h00, q);
		chk("clamp", q, 8'h01);
		chk("bypass", q[0], 1'b1);
		sleep <= 1'b0;
		acc = 8'h00;
		repeat (6)
		begin
			@(posedge clk_i);
			acc = acc | flag;
		end
		chk("wake", acc, 8'hFE);
	endtask
	task automatic t_kbo();
		lowp <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk("kbo", kbo, 1'b0);
		lowp <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk("kbo", kbo, 1'b1);
	endtask
	initial
	begin
		{cyc, stb, we, sleep, lowp} = 5'h00;
		rst_i = 1'b1;
		adr = 10'h000;
		sel = 4'h1;
		wdat = 32'h0000_0000;
		{inten, ext_en, ext_val} = 24'h00_0000;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_pins();
		t_pud();
		t_led();
		t_sleep();
		t_kbo();
		end_sim();
	end
	initial
	begin
		#20000;
		num_errors++;
		end_sim();
	end
endmodule
